// File: hdl/clkdiv_defines.svh
`ifndef CLKDIV_DEFINES_SVH
`define CLKDIV_DEFINES_SVH

// ==========================================
// register offsets
`define CTRL_OFF 12'h000
`define STATUS_OFF 12'h004
`define RATIO_LO_OFF 12'h008
`define RATIO_HI_OFF 12'h00c

// ==========================================
// field positions and reset values
`define CTRL_EN_A_BIT 0
`define CTRL_EN_B_BIT 1
`define CTRL_RESET 2'h3
`define STAT_PIN_BIT 0
`define STAT_SEL1_LSB 1
`define STAT_SEL2_LSB 3
`define STAT_SEL3_LSB 5
`define RATIO_UPPER_LSB 16

// ==========================================
// divide ratios
`define DIV_BY1 10'h001
`define DIV_BY2 10'h002
`define DIV_BY4 10'h004
`define DIV_BY8 10'h008
`define DIV_BY16 10'h010
`define DIV_BY512 10'h200

`endif

// File: hdl/clkdiv_pkg.sv
package clkdiv_pkg;
  // ==========================================
  // three-level strap code; code 3 is illegal
  typedef enum logic [1:0] {
    sel_low,
    sel_mid,
    sel_high
  } select_level_t;

  typedef logic [9:0] ratio_t;
endpackage : clkdiv_pkg

// File: hdl/strap_sync.sv
`timescale 1ns/1ps
module strap_sync #(
  parameter int WIDTH = 7
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_q;

  initial begin
    if (WIDTH < 1) $error("strap_sync: WIDTH must be positive");
  end

  // ==========================================
  // two-stage synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : strap_sync

// File: hdl/group_divider.sv
`timescale 1ns/1ps
module group_divider #(
  parameter int RATIO_W = 10
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire logic tick,
  input wire logic [RATIO_W-1:0] ratio,
  output logic pulse
);
  logic [RATIO_W-1:0] count_q;

  initial begin
    if (RATIO_W < 10) $error("group_divider: RATIO_W too small for 512");
  end

  // ==========================================
  // one pulse per ratio input ticks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= '0;
      pulse <= 1'b0;
    end else if (!enable) begin
      count_q <= '0;
      pulse <= 1'b0;
    end else if (tick) begin
      if (count_q >= ratio - RATIO_W'(1)) begin
        count_q <= '0;
        pulse <= 1'b1;
      end else begin
        count_q <= count_q + RATIO_W'(1);
        pulse <= 1'b0;
      end
    end else begin
      pulse <= 1'b0;
    end
  end

  // ==========================================
  // assertions
  a_div_unity: assert property (@(posedge pclk) disable iff (!presetn)
    enable && tick && ratio == RATIO_W'(1) |=> pulse) else $error("unity ratio missed a pulse");
  a_div_needs_tick: assert property (@(posedge pclk) disable iff (!presetn)
    pulse |-> $past(tick) && $past(enable)) else $error("pulse without tick");
endmodule : group_divider

// File: hdl/pin_strap_clock_divider_config.sv
// Functional notes
// [RL1] first input feeds eight-output bank, second feeds six-output bank, independently
// [RL2] fourteen divided outputs in total, each dividing its bank input
// [RL3] pin control low: groups 0-3, 4-7, 8-11 divide 1/4/2 for low/mid/high
// [RL4] pin control low: outputs 12-13 divide 8/512/16 for low/mid/high
// [RL5] pin control high: first select sets outputs 0-7 to 1/4/2
// [RL6] pin control high: second select sets outputs 8-11 to 1/4/2
// [RL7] pin control high: third select sets outputs 12-13 to 4/512/16
// [RL8] strap driver keeps three-level codes stable while affected outputs are used
//
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "clkdiv_defines.svh"
module pin_strap_clock_divider_config #(
  parameter int NUM_FIRST = 8,
  parameter int NUM_SECOND = 6
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pin_ctrl_enable,
  input wire logic [1:0] divider_select_first,
  input wire logic [1:0] divider_select_second,
  input wire logic [1:0] divider_select_third,
  input wire logic bank_tick_first,
  input wire logic bank_tick_second,
  output logic [13:0] clock_output_channel
);
  import clkdiv_pkg::*;

  initial begin
    if (NUM_FIRST != 8 || NUM_SECOND != 6) $error("bank sizes must be 8 and 6");
  end

  // ==========================================
  // strap synchronisation
  logic [6:0] strap_s;
  logic pin_s;
  select_level_t sel1_s;
  select_level_t sel2_s;
  select_level_t sel3_s;

  strap_sync #(.WIDTH(7)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({divider_select_third, divider_select_second, divider_select_first, pin_ctrl_enable}),
    .q(strap_s)
  );

  assign pin_s = strap_s[0];
  assign sel1_s = select_level_t'(strap_s[2:1]);
  assign sel2_s = select_level_t'(strap_s[4:3]);
  assign sel3_s = select_level_t'(strap_s[6:5]);

  // ==========================================
  // ratio decoding
  function automatic ratio_t std_ratio(input select_level_t lvl);
    unique case (lvl)
      sel_low: std_ratio = `DIV_BY1;
      sel_mid: std_ratio = `DIV_BY4;
      sel_high: std_ratio = `DIV_BY2;
      default: std_ratio = `DIV_BY1;
    endcase
  endfunction : std_ratio

  function automatic ratio_t wide_ratio(input select_level_t lvl, input ratio_t low_val);
    unique case (lvl)
      sel_low: wide_ratio = low_val;
      sel_mid: wide_ratio = `DIV_BY512;
      sel_high: wide_ratio = `DIV_BY16;
      default: wide_ratio = low_val;
    endcase
  endfunction : wide_ratio

  ratio_t ratio0_q;
  ratio_t ratio1_q;
  ratio_t ratio2_q;
  ratio_t ratio3_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ratio0_q <= `DIV_BY1;
      ratio1_q <= `DIV_BY1;
      ratio2_q <= `DIV_BY1;
      ratio3_q <= `DIV_BY8;
    end else if (pin_s) begin
      ratio0_q <= std_ratio(sel1_s); // RL5
      ratio1_q <= std_ratio(sel1_s); // RL5
      ratio2_q <= std_ratio(sel2_s); // RL6
      ratio3_q <= wide_ratio(sel3_s, `DIV_BY4); // RL7
    end else begin
      ratio0_q <= std_ratio(sel1_s); // RL3
      ratio1_q <= std_ratio(sel2_s); // RL3
      ratio2_q <= std_ratio(sel3_s); // RL3
      ratio3_q <= wide_ratio(sel3_s, `DIV_BY8); // RL4
    end
  end

  // ==========================================
  // apb slave
  logic [1:0] ctrl_q;
  logic access;
  logic done;
  logic [31:0] rdata_d;
  logic err_d;

  assign access = psel && penable && !pready;
  assign done = psel && penable && pready;

  always_comb begin
    rdata_d = 32'h0000_0000;
    err_d = 1'b0;
    unique case (paddr)
      `CTRL_OFF: rdata_d[1:0] = ctrl_q;
      `STATUS_OFF: begin
        rdata_d[`STAT_PIN_BIT] = pin_s;
        rdata_d[`STAT_SEL1_LSB +: 2] = sel1_s;
        rdata_d[`STAT_SEL2_LSB +: 2] = sel2_s;
        rdata_d[`STAT_SEL3_LSB +: 2] = sel3_s;
        err_d = pwrite;
      end
      `RATIO_LO_OFF: begin
        rdata_d[9:0] = ratio0_q;
        rdata_d[`RATIO_UPPER_LSB +: 10] = ratio1_q;
        err_d = pwrite;
      end
      `RATIO_HI_OFF: begin
        rdata_d[9:0] = ratio2_q;
        rdata_d[`RATIO_UPPER_LSB +: 10] = ratio3_q;
        err_d = pwrite;
      end
      default: err_d = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= access;
      prdata <= access && !pwrite ? rdata_d : 32'h0000_0000;
      pslverr <= access && err_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `CTRL_RESET;
    end else if (done && pwrite && paddr == `CTRL_OFF && pstrb[0]) begin
      ctrl_q <= pwdata[1:0];
    end
  end

  // ==========================================
  // bank dividers
  logic [3:0] grp_pulse;

  group_divider #(.RATIO_W(10)) u_grp0 (
    .pclk(pclk),
    .presetn(presetn),
    .enable(ctrl_q[`CTRL_EN_A_BIT]),
    .tick(bank_tick_first), // RL1
    .ratio(ratio0_q),
    .pulse(grp_pulse[0])
  );

  group_divider #(.RATIO_W(10)) u_grp1 (
    .pclk(pclk),
    .presetn(presetn),
    .enable(ctrl_q[`CTRL_EN_A_BIT]),
    .tick(bank_tick_first), // RL1
    .ratio(ratio1_q),
    .pulse(grp_pulse[1])
  );

  group_divider #(.RATIO_W(10)) u_grp2 (
    .pclk(pclk),
    .presetn(presetn),
    .enable(ctrl_q[`CTRL_EN_B_BIT]),
    .tick(bank_tick_second), // RL1
    .ratio(ratio2_q),
    .pulse(grp_pulse[2])
  );

  group_divider #(.RATIO_W(10)) u_grp3 (
    .pclk(pclk),
    .presetn(presetn),
    .enable(ctrl_q[`CTRL_EN_B_BIT]),
    .tick(bank_tick_second), // RL1
    .ratio(ratio3_q),
    .pulse(grp_pulse[3])
  );

  // fan groups out to the fourteen channels
  assign clock_output_channel = {{2{grp_pulse[3]}}, {4{grp_pulse[2]}},
    {4{grp_pulse[1]}}, {4{grp_pulse[0]}}}; // RL2

  // ==========================================
  // assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_low_first_grp: assert property ( // RL3
    !pin_s && sel1_s == sel_mid |=> ratio0_q == `DIV_BY4)
    else $error("low mode first group ratio wrong");
  a_low_third_grps: assert property ( // RL4
    !pin_s && sel3_s == sel_mid |=> ratio3_q == `DIV_BY512 && ratio2_q == `DIV_BY4)
    else $error("low mode third select ratios wrong");
  a_low_wide_default: assert property ( // RL4
    !pin_s && sel3_s == sel_low |=> ratio3_q == `DIV_BY8)
    else $error("low mode wide low ratio wrong");
  a_high_bank_common: assert property ( // RL5
    pin_s && sel1_s == sel_high |=> ratio0_q == `DIV_BY2 && ratio1_q == `DIV_BY2)
    else $error("high mode bank ratio not common");
  a_high_second_grp: assert property ( // RL6
    pin_s && sel2_s == sel_mid |=> ratio2_q == `DIV_BY4)
    else $error("high mode second group ratio wrong");
  a_high_wide_low: assert property ( // RL7
    pin_s && sel3_s == sel_low |=> ratio3_q == `DIV_BY4)
    else $error("high mode wide low ratio wrong");
  a_bank_second_route: assert property ( // RL1
    |clock_output_channel[13:8] |-> $past(bank_tick_second))
    else $error("second bank pulse without its tick");
  a_bank_first_route: assert property ( // RL1
    |clock_output_channel[7:0] |-> $past(bank_tick_first))
    else $error("first bank pulse without its tick");
  a_bank_off_quiet: assert property ( // RL2
    !ctrl_q[`CTRL_EN_B_BIT] |=> clock_output_channel[13:8] == 6'h00)
    else $error("disabled bank still pulses");
  a_apb_ready_next: assert property (
    access |=> pready ##1 !pready)
    else $error("apb answer not one cycle");
  a_low_first_unity: assert property ( // RL3
    !pin_s && sel1_s == sel_low |=> ratio0_q == `DIV_BY1)
    else $error("low mode first group unity wrong");
  a_low_second_grp: assert property ( // RL3
    !pin_s && sel2_s == sel_high |=> ratio1_q == `DIV_BY2)
    else $error("low mode second group ratio wrong");
  a_low_second_mid: assert property ( // RL3
    !pin_s && sel2_s == sel_mid |=> ratio1_q == `DIV_BY4)
    else $error("low mode second group middle wrong");
  a_low_third_low: assert property ( // RL3
    !pin_s && sel3_s == sel_low |=> ratio2_q == `DIV_BY1)
    else $error("low mode third group unity wrong");
  a_low_wide_high: assert property ( // RL4
    !pin_s && sel3_s == sel_high |=> ratio3_q == `DIV_BY16 && ratio2_q == `DIV_BY2)
    else $error("low mode wide high ratio wrong");
  a_high_bank_mid: assert property ( // RL5
    pin_s && sel1_s == sel_mid |=> ratio0_q == `DIV_BY4 && ratio1_q == `DIV_BY4)
    else $error("high mode bank middle ratio wrong");
  a_high_bank_low: assert property ( // RL5
    pin_s && sel1_s == sel_low |=> ratio0_q == `DIV_BY1 && ratio1_q == `DIV_BY1)
    else $error("high mode bank unity ratio wrong");
  a_high_second_low: assert property ( // RL6
    pin_s && sel2_s == sel_low |=> ratio2_q == `DIV_BY1)
    else $error("high mode second group unity wrong");
  a_high_second_high: assert property ( // RL6
    pin_s && sel2_s == sel_high |=> ratio2_q == `DIV_BY2)
    else $error("high mode second group high wrong");
  a_high_wide_mid: assert property ( // RL7
    pin_s && sel3_s == sel_mid |=> ratio3_q == `DIV_BY512)
    else $error("high mode wide middle ratio wrong");
  a_high_wide_high: assert property ( // RL7
    pin_s && sel3_s == sel_high |=> ratio3_q == `DIV_BY16)
    else $error("high mode wide high ratio wrong");
  a_bank_first_quiet: assert property ( // RL2
    !ctrl_q[`CTRL_EN_A_BIT] |=> clock_output_channel[7:0] == 8'h00)
    else $error("disabled first bank still pulses");

  // ==========================================
  // apb and control assertions
  a_apb_err_ready: assert property (
    pslverr |-> pready)
    else $error("error flag outside answer cycle");
  a_apb_idle_zero: assert property (
    !pready |-> prdata == 32'h0000_0000 && !pslverr)
    else $error("read data or error outside answer cycle");
  a_apb_ro_write: assert property (
    done && pwrite && paddr == `RATIO_LO_OFF |-> pslverr)
    else $error("write to read-only register not refused");
  a_apb_unmapped: assert property (
    done && paddr == 12'h010 |-> pslverr)
    else $error("unmapped address not refused");
  a_ctrl_idle_hold: assert property (
    !done |=> $stable(ctrl_q))
    else $error("control changed without a transfer");
  a_ctrl_strobe_off: assert property (
    done && pwrite && !pstrb[0] |=> $stable(ctrl_q))
    else $error("control changed on masked write");

  // ==========================================
  // cover points
  c_wide_512: cover property (pin_s && sel3_s == sel_mid ##1 grp_pulse[3]);
  c_ctrl_write: cover property (done && pwrite && paddr == `CTRL_OFF);
  c_unity_pass: cover property (ratio0_q == `DIV_BY1 && bank_tick_first ##1 grp_pulse[0]);
  c_bank_first_off: cover property (!ctrl_q[`CTRL_EN_A_BIT] && bank_tick_first);
  c_apb_error: cover property (done && pslverr);
endmodule : pin_strap_clock_divider_config

// File: dv/strap_model.sv
`timescale 1ns/1ps
// ==========================================
// board strap driver
module strap_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire logic [6:0] code,
  output logic pin_ctrl_enable,
  output logic [1:0] divider_select_first,
  output logic [1:0] divider_select_second,
  output logic [1:0] divider_select_third
);
  // codes move only on load, held stable otherwise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {divider_select_third, divider_select_second, divider_select_first, pin_ctrl_enable} <= 7'h00;
    end else if (load) begin
      {divider_select_third, divider_select_second, divider_select_first, pin_ctrl_enable} <= code;
    end
  end
endmodule : strap_model

// File: dv/pin_strap_clock_divider_config_tb.sv
`timescale 1ns/1ps
`include "clkdiv_defines.svh"
module pin_strap_clock_divider_config_tb;
  import clkdiv_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic pin_en;
  logic [1:0] s1, s2, s3;
  logic tick_a = 1'b0;
  logic tick_b = 1'b0;
  logic [13:0] ch;
  logic load = 1'b0;
  logic [6:0] code = 7'h00;
  logic [31:0] rd;
  logic err;
  int seed = 51;
  int miscompares = 0;
  int total_checks = 0;
  int cyc = 0;
  int ta, tb;
  int pulses [14];

  pin_strap_clock_divider_config uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_ctrl_enable(pin_en),
    .divider_select_first(s1), .divider_select_second(s2), .divider_select_third(s3),
    .bank_tick_first(tick_a), .bank_tick_second(tick_b), .clock_output_channel(ch));
  strap_model straps (.pclk(pclk), .presetn(presetn), .load(load), .code(code),
    .pin_ctrl_enable(pin_en), .divider_select_first(s1), .divider_select_second(s2),
    .divider_select_third(s3));

  // ==========================================
  // clock, timeout, tick and pulse counters
  initial begin
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    ta += (tick_a === 1'b1);
    tb += (tick_b === 1'b1);
    for (int i = 0; i < 14; i++) pulses[i] += (ch[i] === 1'b1);
    if (cyc == 5000) begin
      miscompares++;
      complete_run();
    end
  end

  // ==========================================
  // helpers
  function automatic ratio_t std_r(input logic [1:0] l);
    return (l == 2'd1) ? `DIV_BY4 : (l == 2'd2) ? `DIV_BY2 : `DIV_BY1;
  endfunction : std_r
  function automatic ratio_t wide_r(input logic p, input logic [1:0] l);
    return (l == 2'd1) ? `DIV_BY512 : (l == 2'd2) ? `DIV_BY16 : (p ? `DIV_BY4 : `DIV_BY8);
  endfunction : wide_r
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
      input logic [3:0] s);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic set_straps(input logic [6:0] c);
    code <= c;
    load <= 1'b1;
    @(posedge pclk);
    load <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask : set_straps
  task automatic check_tables(input logic p, input logic [1:0] a, input logic [1:0] b,
      input logic [1:0] c);
    ratio_t g0, g1, g2, g3;
    set_straps({c, b, a, p});
    g0 = std_r(a);
    g1 = p ? g0 : std_r(b);
    g2 = p ? std_r(b) : std_r(c);
    g3 = wide_r(p, c);
    apb(1'b0, `RATIO_LO_OFF, 32'h0, 4'h0);
    chk(rd, {6'h0, g1, 6'h0, g0});
    chk({31'h0, err}, 32'h0);
    apb(1'b0, `RATIO_HI_OFF, 32'h0, 4'h0);
    chk(rd, {6'h0, g3, 6'h0, g2});
    apb(1'b0, `STATUS_OFF, 32'h0, 4'h0);
    chk(rd, {25'h0, c, b, a, p});
  endtask : check_tables
  task automatic run_ticks(input int n);
    ta = 0;
    tb = 0;
    for (int i = 0; i < 14; i++) pulses[i] = 0;
    repeat (n) begin
      tick_a <= 1'($random(seed));
      tick_b <= 1'($random(seed));
      @(posedge pclk);
    end
    tick_a <= 1'b0;
    tick_b <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask : run_ticks
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  // ==========================================
  // main sequence
  initial begin
    logic p;
    logic [1:0] a, b, c;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `CTRL_OFF, 32'h0, 4'h0);
    chk(rd, 32'h3);
    for (int m = 0; m < 2; m++) begin
      for (int l = 0; l < 3; l++) begin
        check_tables(1'(m), 2'(l), 2'((l + 1) % 3), 2'((l + 2) % 3));
      end
    end
    for (int r = 0; r < 8; r++) begin
      p = 1'($random(seed));
      a = 2'($unsigned($random(seed)) % 3);
      b = 2'($unsigned($random(seed)) % 3);
      c = 2'($unsigned($random(seed)) % 3);
      check_tables(p, a, b, c);
    end
    $display("test ratio tables done");
    set_straps({2'd0, 2'd2, 2'd1, 1'b1});
    run_ticks(240);
    for (int i = 0; i < 8; i++) chk(32'(pulses[i]), 32'(ta / 4));
    for (int i = 8; i < 12; i++) chk(32'(pulses[i]), 32'(tb / 2));
    for (int i = 12; i < 14; i++) chk(32'(pulses[i]), 32'(tb / 4));
    $display("test bank division done");
    apb(1'b1, `CTRL_OFF, 32'h0, 4'h1);
    apb(1'b1, `CTRL_OFF, 32'h2, 4'h1);
    apb(1'b1, `CTRL_OFF, 32'h0, 4'h0);
    apb(1'b0, `CTRL_OFF, 32'h0, 4'h0);
    chk(rd, 32'h2);
    run_ticks(40);
    chk(32'(pulses[0] + pulses[7]), 32'h0);
    chk(32'(pulses[8]), 32'(tb / 2));
    chk(32'(pulses[12]), 32'(tb / 4));
    apb(1'b0, 12'h010, 32'h0, 4'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, `RATIO_LO_OFF, 32'hffff, 4'hf);
    chk({31'h0, err}, 32'h1);
    $display("test control and errors done");
    complete_run();
  end
endmodule : pin_strap_clock_divider_config_tb
